// ---- design/bcu_core.v ----
/*
 branch and call unit: computes the next program counter for the rotate-and-mask
 jump, far subroutine entries and far branches, and pushes return context.
 every result is registered: pc_reg, taken_reg and push_reg answer one clock
 after the cycle in which op_valid is high; taken_reg and push_reg are pulses.
 stack_entry_reg carries the entry to push while push_reg stands and holds
 between pushes; flags_we stays low, no control transfer touches the flags.
 it owns no storage beyond its result registers and the entry it presents.
 assumes decode presents one operation per cycle with operands already fetched,
 and the register file supplies the active register value and index register.
 assumes pc_next_insn already points past the whole instruction, both words of
 a two-word one, and that the address stack and register banks live elsewhere.
*/
`timescale 1ns/1ps
`include "bcu_defines.vh"

module bcu_core #(
    parameter DW = 8
) (
    input  wire                     mclk,
    input  wire                     rst_b,
    input  wire                     op_valid,
    input  wire [2:0]               op_sel,
    input  wire [`BCU_PC_W-1:0]     pc_next_insn,
    input  wire [DW-1:0]            src_val,
    input  wire [2:0]               rot_amt,
    input  wire [2:0]               mask_cnt,
    input  wire [2:0]               bit_pos,
    input  wire                     bit_state,
    input  wire [`BCU_PC_W-1:0]     abs_target,
    input  wire [`BCU_PC_W-1:0]     index_addr,
    input  wire [`BCU_FLAG_W-1:0]   alu_flags,
    input  wire                     global_irq_enable,
    input  wire                     bank_a_alt,
    input  wire                     bank_b_alt,
    output reg  [`BCU_PC_W-1:0]     pc_reg,
    output reg                      taken_reg,
    output reg                      push_reg,
    output reg  [`BCU_ENT_W-1:0]    stack_entry_reg,
    output wire                     flags_we
);
    // displacement and targets
    wire [`BCU_PC_W-1:0]   disp;
    wire [`BCU_PC_W-1:0]   rot_target;

    // bit test
    wire [DW-1:0]          bit_sel;
    wire [DW-1:0]          bit_hit;
    wire                   bit_match;

    // decoded operation
    reg  [1:0]             tgt_sel;
    reg                    need_bit;
    reg                    is_call;
    wire                   cond_ok;
    wire                   take_xfer;

    // next-state values
    reg  [`BCU_PC_W-1:0]   pc_next;
    reg                    taken_next;
    reg                    push_next;
    reg  [`BCU_ENT_W-1:0]  stack_entry_next;

    // where the new program counter comes from
    localparam [1:0] TGT_FALL = 2'h0;
    localparam [1:0] TGT_ROT  = 2'h1;
    localparam [1:0] TGT_ABS  = 2'h2;
    localparam [1:0] TGT_IDX  = 2'h3;

    // rotate, mask and sign-extension of the register copy
    bcu_disp #(
        .DW       (DW)
    ) u_disp (
        .src_val  (src_val),
        .rot_amt  (rot_amt),
        .mask_cnt (mask_cnt),
        .disp     (disp)
    );

    // bit test: the one-hot position picks a single register bit
    // a position beyond the register width selects nothing and so never matches
    assign bit_sel = {{(DW-1){1'b0}}, 1'b1} << bit_pos;

    genvar b;
    generate
        for (b = 0; b < DW; b = b + 1) begin : g_bit
            assign bit_hit[b] = bit_sel[b] & ~(src_val[b] ^ bit_state);
        end
    endgenerate

    assign bit_match = |bit_hit;

    // decode: target source, whether a bit is tested, whether context is pushed
    // unknown codes and op_valid low both fall through, so a stray code
    // can never push an entry onto the stack
    always @* begin
        tgt_sel  = TGT_FALL;
        need_bit = 1'b0;
        is_call  = 1'b0;
        if (op_valid) begin
            case (op_sel)
                `BCU_OP_ROT_MASK: begin
                    tgt_sel = TGT_ROT;
                end
                `BCU_OP_CALL_COND: begin
                    tgt_sel  = TGT_ABS;
                    need_bit = 1'b1;
                    is_call  = 1'b1;
                end
                `BCU_OP_CALL_ALWAYS: begin
                    tgt_sel = TGT_ABS;
                    is_call = 1'b1;
                end
                `BCU_OP_BR_COND: begin
                    tgt_sel  = TGT_ABS;
                    need_bit = 1'b1;
                end
                `BCU_OP_BR_ABS: begin
                    tgt_sel = TGT_ABS;
                end
                `BCU_OP_BR_INDEX: begin
                    tgt_sel = TGT_IDX;
                end
                default: begin
                    tgt_sel = TGT_FALL;
                end
            endcase
        end
    end

    // a conditional code whose bit misses acts as no operation
    assign cond_ok   = !need_bit || bit_match;
    assign take_xfer = (tgt_sel != TGT_FALL) && cond_ok;

    // table jump is relative to the instruction after the jump
    // the 16-bit add wraps around the ends of instruction memory
    assign rot_target = pc_next_insn + disp;

    // next program counter; a miss or idle cycle falls through past both words
    always @* begin
        pc_next = pc_next_insn;
        if (take_xfer) begin
            case (tgt_sel)
                TGT_ROT: begin
                    pc_next = rot_target;
                end
                TGT_ABS: begin
                    pc_next = abs_target;
                end
                TGT_IDX: begin
                    pc_next = index_addr;
                end
                default: begin
                    pc_next = pc_next_insn;
                end
            endcase
        end
    end

    // only a call that is taken pushes; branches and misses leave the stack alone
    always @* begin
        taken_next = take_xfer;
        push_next  = take_xfer && is_call;
    end

    // return context as one entry, built field by field
    // the saved address is pc_next_insn, not the target, so a return resumes
    // after both words of the call
    always @* begin
        stack_entry_next = stack_entry_reg;
        if (push_next) begin
            stack_entry_next[`BCU_ENT_PC_LSB +: `BCU_PC_W]     = pc_next_insn;
            stack_entry_next[`BCU_ENT_FLAG_LSB +: `BCU_FLAG_W] = alu_flags;
            stack_entry_next[`BCU_ENT_IRQ_BIT]                 = global_irq_enable;
            stack_entry_next[`BCU_ENT_BANKA_BIT]               = bank_a_alt;
            stack_entry_next[`BCU_ENT_BANKB_BIT]               = bank_b_alt;
        end
    end

    // result registers answer one clock after the operation is taken;
    // taken_reg and push_reg stand for that one cycle only
    always @(posedge mclk) begin
        if (!rst_b) begin
            pc_reg    <= `BCU_PC_RESET;
            taken_reg <= 1'b0;
            push_reg  <= 1'b0;
        end else begin
            pc_reg    <= pc_next;
            taken_reg <= taken_next;
            push_reg  <= push_next;
        end
    end

    // entry holds between pushes; bank selections are only copied, never driven
    always @(posedge mclk) begin
        if (!rst_b) begin
            stack_entry_reg <= {`BCU_ENT_W{1'b0}};
        end else begin
            stack_entry_reg <= stack_entry_next;
        end
    end

    // control transfers never write the arithmetic flags
    assign flags_we = 1'b0;
endmodule

// ---- design/bcu_defines.vh ----
/*
 holds constants for the branch and call unit: operation codes, field widths,
 stack entry layout. assumes inclusion by bare name from design files.
*/
`ifndef BCU_DEFINES_VH
`define BCU_DEFINES_VH

// operation select codes on op_sel
`define BCU_OP_NONE        3'h0
`define BCU_OP_ROT_MASK    3'h1
`define BCU_OP_CALL_COND   3'h2
`define BCU_OP_CALL_ALWAYS 3'h3
`define BCU_OP_BR_COND     3'h4
`define BCU_OP_BR_ABS      3'h5
`define BCU_OP_BR_INDEX    3'h6

// widths
`define BCU_PC_W           16
`define BCU_FLAG_W         4

// stack entry: {bank_b, bank_a, irq_en, flags[3:0], pc[15:0]}
`define BCU_ENT_PC_LSB     0
`define BCU_ENT_FLAG_LSB   16
`define BCU_ENT_IRQ_BIT    20
`define BCU_ENT_BANKA_BIT  21
`define BCU_ENT_BANKB_BIT  22
`define BCU_ENT_W          23

// reset value of the program counter
`define BCU_PC_RESET       16'h0000

`endif

// ---- design/bcu_disp.v ----
/*
 rotate-and-mask displacement former for the branch and call unit.
 purely combinational; the caller supplies a register copy and the operands.
*/
`timescale 1ns/1ps
`include "bcu_defines.vh"

module bcu_disp #(
    parameter DW = 8
) (
    input  wire [DW-1:0]            src_val,
    input  wire [2:0]               rot_amt,
    input  wire [2:0]               mask_cnt,
    output wire [`BCU_PC_W-1:0]     disp
);
    wire [2*DW-1:0] dbl;
    wire [DW-1:0]   rotated;
    wire [DW-1:0]   keep;
    wire [DW-1:0]   masked;

    // rotate right by 0..7, zero gives the copy unchanged
    assign dbl     = {src_val, src_val} >> rot_amt;
    assign rotated = dbl[DW-1:0];

    genvar i;
    generate
        for (i = 0; i < DW; i = i + 1) begin : g_mask
            if (i == 0) begin : g_lsb
                assign keep[i] = 1'b0;
            end else begin : g_hi
                // bit i cleared when it lies among the top mask_cnt bits
                assign keep[i] = ((DW - 1 - i) >= mask_cnt) ? 1'b1 : 1'b0;
            end
        end
    endgenerate

    assign masked = rotated & keep;
    assign disp   = {{(`BCU_PC_W-DW){masked[DW-1]}}, masked};
endmodule

// ---- test/bcu_core_props.sv ----
/* concurrent checks on the ports of bcu_core.
 assumes the op_sel codes and entry layout of bcu_defines.vh */
`timescale 1ns/1ps
`include "bcu_defines.vh"
module bcu_props (
    input wire        mclk, rst_b, op_valid, bit_state, global_irq_enable, bank_a_alt, bank_b_alt,
    input wire [2:0]  op_sel, bit_pos, rot_amt, mask_cnt,
    input wire [7:0]  src_val,
    input wire [3:0]  alu_flags,
    input wire [15:0] pc_next_insn, abs_target, index_addr, pc_reg,
    input wire        taken_reg, push_reg, flags_we,
    input wire [22:0] stack_entry_reg
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    wire       hit = src_val[bit_pos] == bit_state;
    wire [2:0] s   = op_valid ? op_sel : 3'h0;
    chk_no_flag_write: assert property (flags_we == 1'b0) else $error("flags written");
    chk_rot_even: assert property (s == 3'h1 |=> taken_reg && !push_reg
        && pc_reg[0] == $past(pc_next_insn[0])) else $error("odd displacement");
    chk_call_always: assert property (s == 3'h3 |=> push_reg && taken_reg
        && pc_reg == $past(abs_target)) else $error("call not taken");
    chk_call_entry: assert property (s == 3'h3 || (s == 3'h2 && hit) |=> stack_entry_reg ==
        $past({bank_b_alt, bank_a_alt, global_irq_enable, alu_flags, pc_next_insn})) else $error("bad entry");
    chk_cond_call: assert property (s == 3'h2 && hit |=> push_reg && taken_reg
        && pc_reg == $past(abs_target)) else $error("cond call");
    chk_cond_branch: assert property (s == 3'h4 && hit |=> taken_reg && !push_reg
        && pc_reg == $past(abs_target)) else $error("cond branch");
    chk_cond_miss: assert property ((s == 3'h2 || s == 3'h4) && !hit |=> !taken_reg && !push_reg
        && pc_reg == $past(pc_next_insn)) else $error("miss taken");
    chk_far_branch: assert property (s == 3'h5 || s == 3'h6 |=> !push_reg && pc_reg ==
        $past(s == 3'h5 ? abs_target : index_addr)) else $error("far branch");
    chk_rot_reach: assert property (s == 3'h1 |=>
        pc_reg - $past(pc_next_insn) + 16'h0080 <= 16'h00FE) else $error("jump out of reach");
    chk_rot_plain: assert property (s == 3'h1 && rot_amt == 3'h0 && mask_cnt == 3'h0 |=>
        pc_reg == $past(pc_next_insn + {{8{src_val[7]}}, src_val & 8'hFE})) else $error("unrotated jump");
    chk_entry_hold: assert property ($past(rst_b) && !push_reg |-> $stable(stack_entry_reg))
        else $error("entry changed");
    cover property (s == 3'h3);
    cover property (s == 3'h2 && hit);
    cover property (s == 3'h1 && mask_cnt == 3'h7);
    cover property ((s == 3'h2 || s == 3'h4) && !hit);
endmodule
bind bcu_core bcu_props chk (.mclk(mclk), .rst_b(rst_b), .op_valid(op_valid), .bit_state(bit_state),
    .rot_amt(rot_amt), .mask_cnt(mask_cnt),
    .global_irq_enable(global_irq_enable), .bank_a_alt(bank_a_alt), .bank_b_alt(bank_b_alt),
    .op_sel(op_sel), .bit_pos(bit_pos), .src_val(src_val), .alu_flags(alu_flags),
    .pc_next_insn(pc_next_insn), .abs_target(abs_target), .index_addr(index_addr), .pc_reg(pc_reg),
    .taken_reg(taken_reg), .push_reg(push_reg), .flags_we(flags_we), .stack_entry_reg(stack_entry_reg));

// ---- test/tb.sv ----
/* self-checking bench for bcu_core.
 assumes the op_sel codes and entry layout of bcu_defines.vh */
`timescale 1ns/1ps
`include "bcu_defines.vh"
module tb;
    reg         mclk = 0, rst_b = 0, op_valid = 0, bit_state = 0, irq = 0, ba = 0, bb = 0;
    reg  [2:0]  op_sel = 0, rot_amt = 0, mask_cnt = 0, bit_pos = 0;
    reg  [7:0]  src_val = 0;
    reg  [3:0]  alu_flags = 0;
    reg  [15:0] pc_n = 0, abs_t = 0, idx = 0;
    wire [15:0] pc_reg;
    wire [22:0] ent;
    wire        taken_reg, push_reg, flags_we;
    integer     miscompares = 0, cmp_count = 0, i;
    reg         m;
    bcu_core dut (.mclk(mclk), .rst_b(rst_b), .op_valid(op_valid), .op_sel(op_sel), .pc_next_insn(pc_n),
        .src_val(src_val), .rot_amt(rot_amt), .mask_cnt(mask_cnt), .bit_pos(bit_pos), .bit_state(bit_state),
        .abs_target(abs_t), .index_addr(idx), .alu_flags(alu_flags), .global_irq_enable(irq),
        .bank_a_alt(ba), .bank_b_alt(bb), .pc_reg(pc_reg), .taken_reg(taken_reg), .push_reg(push_reg),
        .stack_entry_reg(ent), .flags_we(flags_we));
    initial forever #12.5 mclk = ~mclk;
    task chk(input ok); begin
        cmp_count = cmp_count + 1;
        if (ok !== 1'b1) begin
            miscompares = miscompares + 1;
            $display("ERROR %0t mismatch", $time);
        end
    end endtask
    // one operation: result is due one edge later
    task step(input [2:0] s, input [15:0] ep, input et, input eu); begin
        op_sel = s;
        @(posedge mclk);
        #2;
        chk(pc_reg === ep && taken_reg === et && push_reg === eu && flags_we === 1'b0);
    end endtask
    function [15:0] rdisp(input [7:0] v, input [2:0] b, input [2:0] k);
        reg [7:0] r;
        begin
            r = (v >> b) | (v << (8 - b));
            r = r & (8'hFF >> k) & 8'hFE;
            rdisp = {{8{r[7]}}, r};
        end
    endfunction
    task t_rot; begin
        for (i = 0; i < 128; i = i + 1) begin
            pc_n = i[6] ? 16'hFF80 : 16'h0042;
            src_val = i * 8'h5B + 8'h81;
            rot_amt = i[2:0];
            mask_cnt = i[5:3];
            step(`BCU_OP_ROT_MASK, pc_n + rdisp(src_val, rot_amt, mask_cnt), 1'b1, 1'b0);
        end
    end endtask
    task t_cond; begin
        for (i = 0; i < 32; i = i + 1) begin
            {bit_state, bit_pos} = i[3:0];
            src_val = 8'h5A ^ i[7:0];
            abs_t = 16'hC000 + i;
            m = src_val[bit_pos] == bit_state;
            step(i[4] ? `BCU_OP_CALL_COND : `BCU_OP_BR_COND, m ? abs_t : pc_n, m, m & i[4]);
        end
    end endtask
    task t_call; begin
        for (i = 0; i < 8; i = i + 1) begin
            {bb, ba, irq} = i[2:0];
            alu_flags = ~i[3:0];
            abs_t = i * 16'h2345 + 16'hFFFF;
            step(`BCU_OP_CALL_ALWAYS, abs_t, 1'b1, 1'b1);
            chk(ent === {bb, ba, irq, alu_flags, pc_n});
        end
    end endtask
    task t_br; begin
        {bb, ba, irq} = 3'b000;
        alu_flags = 4'h0;
        abs_t = 16'hFFFF;
        idx = 16'h8001;
        step(`BCU_OP_BR_ABS, abs_t, 1'b1, 1'b0);
        step(`BCU_OP_BR_INDEX, idx, 1'b1, 1'b0);
        step(3'h7, pc_n, 1'b0, 1'b0);
        op_valid = 0;
        step(`BCU_OP_CALL_ALWAYS, pc_n, 1'b0, 1'b0);
        chk(ent === {3'b111, 4'h8, 16'hFF80});
        rst_b = 0;
        @(posedge mclk);
        #2;
        chk(pc_reg === 16'h0000 && ent === 23'h000000 && push_reg === 1'b0);
        rst_b = 1;
        op_valid = 1;
        step(`BCU_OP_BR_ABS, abs_t, 1'b1, 1'b0);
    end endtask
    task tally_and_finish; begin
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    end endtask
    initial begin
        #100000;
        miscompares = miscompares + 1;
        tally_and_finish;
    end
    initial begin
        repeat (16) @(posedge mclk);
        #2;
        rst_b = 1;
        op_valid = 1;
        t_rot;
        t_cond;
        t_call;
        t_br;
        tally_and_finish;
    end
endmodule
